// file: rtl/acr_defs.vh
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH

// ****************************************
// Command codes
// ****************************************
`define ACR_CMD_STOP_CONT 8'h11
`define ACR_CMD_READ_DATA 8'h12
`define ACR_CMD_OFS_CAL 8'h60
`define ACR_CMD_GAIN_CAL 8'h61

// ****************************************
// Calibration word layout and reset values
// ****************************************
`define ACR_OFS_RESET 24'h000000
`define ACR_GAIN_RESET 24'h400000
`define ACR_GAIN_SHIFT 22
`define ACR_SEL_OFS_LOW 3'h0
`define ACR_SEL_OFS_MID 3'h1
`define ACR_SEL_OFS_HIGH 3'h2
`define ACR_SEL_GAIN_LOW 3'h4
`define ACR_SEL_GAIN_MID 3'h5
`define ACR_SEL_GAIN_HIGH 3'h6

// ****************************************
// Counts and full-scale codes
// ****************************************
`define ACR_CMD_BITS 4'h8
`define ACR_WORD_BITS 6'h20
`define ACR_CAL_AVG 5'h10
`define ACR_DIV_BITS 6'h35
`define ACR_FS_EXPECTED 32'h7FFFFFFE
`define ACR_POS_FS 32'h7FFFFFFF
`define ACR_NEG_FS 32'h80000000

`endif

// file: rtl/acr_sync.v
`timescale 1ns/100ps
// Three-stage pin synchroniser; output follows once stages two and three agree
module acr_sync
(
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Pin and filtered level
    input wire pin_in,
    output reg level_r
);

reg s1_r;
reg s2_r;
reg s3_r;

// Stage one feeds stage two only, to keep metastability contained
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        level_r <= 1'b0;
    end
    else
    begin
        s1_r <= pin_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r)
            level_r <= s3_r;
    end
end

endmodule

// file: rtl/acr_core.v
`timescale 1ns/100ps
`include "acr_defs.vh"
// Functional notes
// - Stop-continuous command enters command-read; words go out only after read-data command.
// - After eighth rising serial edge of read-data, strobe goes low when word ready.
// - When strobe falls in command-read, MSB is placed on serial out.
// - Chip select high cancels command-read; host must resend stop-continuous first.
// - Result is 32-bit two's complement word, shifted MSB first.
// - FIR path LSB is redundant sign; clipped positive gives 1, clipped negative gives 0.
// - Sinc-only path scales output word by one half.
// - FIR path saturates to maximum positive or most negative code.
// - Subtract offset first, then multiply by gain, before 32-bit clip.
// - One offset and one gain word serve all amplifier gains.
// - Sinc-only mode bypasses correction and ignores calibration commands.
// - Offset word is 24 bits in three bytes, left-justified on the word.
// - Offset word is signed; zero default means no correction.
// - Gain word is unsigned 24 bits; 400000h default means unity.
// - Gain multiplier scales linearly with the gain word.
// - Calibration commands compute and load offset and gain words.
// - Offset calibration averages 16 conversions, truncated 24-bit average into offset.
// - During offset calibration the gain multiplication is bypassed.
// - Gain calibration averages 16 conversions and writes derived multiplier to gain.
// - Codes: stop-continuous 11h, read-data 12h, offset cal 60h, gain cal 61h.
// - During readback the strobe returns high on first falling serial edge.
module acr_core
(
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Serial pins
    input wire cs_n,
    input wire sclk,
    input wire din,
    output reg dout_r,
    output reg dout_oe_n_r,
    output reg data_ready_n_r,
    // Raw conversion stream from the filter
    input wire [31:0] conv_data,
    input wire conv_valid,
    input wire sinc_mode,
    // Calibration byte write port
    input wire reg_wr,
    input wire [2:0] reg_sel,
    input wire [7:0] reg_wdata,
    // Status
    output reg [23:0] offset_corr_word_r,
    output reg [23:0] gain_corr_word_r,
    output reg cmd_read_mode_r,
    output reg cal_busy_r
);

// ****************************************
// Pin synchronisers and edge detection
// ****************************************
localparam CAL_IDLE = 2'h0;
localparam CAL_ACC = 2'h1;
localparam CAL_DIV = 2'h2;

wire cs_sel_s;
wire sclk_s;
wire din_s;
reg sclk_d_r;

// Select is synchronised active high so the cleared stages mean deselected after reset
acr_sync u_sync_cs (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(~cs_n), .level_r(cs_sel_s));
acr_sync u_sync_sclk (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(sclk), .level_r(sclk_s));
acr_sync u_sync_din (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(din), .level_r(din_s));

wire cs_n_s = ~cs_sel_s;
wire sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
wire sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;

// ****************************************
// Offset and gain correction datapath
// ****************************************
reg [1:0] cal_state_r;
reg cal_gain_r;
wire ofs_cal_run = cal_busy_r & ~cal_gain_r;

// Offset sits left-justified on the 32-bit word and is subtracted first
wire signed [33:0] diff = {{2{conv_data[31]}}, conv_data} -
                          {{2{offset_corr_word_r[23]}}, offset_corr_word_r, 8'h00};
// Gain word is unsigned, so a zero bit is prepended before the signed product
wire signed [58:0] prod = diff * $signed({1'b0, gain_corr_word_r});
// Gain multiplication skipped while measuring offset so the result is unscaled
wire signed [36:0] scaled = ofs_cal_run ? {{3{diff[33]}}, diff} :
                            prod[58:`ACR_GAIN_SHIFT];
wire sat_hi = ~scaled[36] & (|scaled[35:31]);
wire sat_lo = scaled[36] & ~(&scaled[35:31]);

reg [31:0] corr_word;

// Clip and redundant sign bit; sinc path bypasses correction at half scale
always @*
begin
    if (sinc_mode)
        corr_word = {conv_data[31], conv_data[31:1]};
    else if (sat_hi)
        corr_word = `ACR_POS_FS;
    else if (sat_lo)
        corr_word = `ACR_NEG_FS;
    else
        corr_word = {scaled[31:1], scaled[31]};
end

// ****************************************
// Latest result holding register
// ****************************************
reg [31:0] result_r;
reg result_new_r;
reg read_pend_r;
reg tx_load;

// A fresh result while the previous one is being loaded re-arms the flag
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        result_r <= 32'h00000000;
        result_new_r <= 1'b0;
    end
    else
    begin
        if (tx_load)
            result_new_r <= 1'b0;
        if (conv_valid)
        begin
            result_r <= corr_word;
            result_new_r <= 1'b1;
        end
    end
end

// ****************************************
// Command receiver and transmit shifter
// ****************************************
reg [7:0] cmd_sh_r;
reg [3:0] cmd_cnt_r;
reg [31:0] tx_sh_r;
reg [5:0] tx_cnt_r;
reg tx_active_r;
reg tx_rise_r;
reg cal_start_r;
reg cal_start_gain_r;
wire [7:0] cmd_byte = {cmd_sh_r[6:0], din_s};
wire cmd_done = sclk_rise & (cmd_cnt_r == `ACR_CMD_BITS - 4'h1);

// Word is only released once a read-data command is pending and a new result is waiting
always @*
begin
    tx_load = read_pend_r & result_new_r & ~cs_n_s & ~tx_active_r;
end

always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        sclk_d_r <= 1'b0;
        cmd_sh_r <= 8'h00;
        cmd_cnt_r <= 4'h0;
        cmd_read_mode_r <= 1'b0;
        read_pend_r <= 1'b0;
        tx_sh_r <= 32'h00000000;
        tx_cnt_r <= 6'h00;
        tx_active_r <= 1'b0;
        tx_rise_r <= 1'b0;
        data_ready_n_r <= 1'b1;
        dout_r <= 1'b0;
        dout_oe_n_r <= 1'b1;
        cal_start_r <= 1'b0;
        cal_start_gain_r <= 1'b0;
    end
    else
    begin
        sclk_d_r <= sclk_s;
        cal_start_r <= 1'b0;
        dout_oe_n_r <= cs_n_s;
        if (cs_n_s)
        begin
            // Deselect ends any transfer and leaves command-read mode
            cmd_read_mode_r <= 1'b0;
            read_pend_r <= 1'b0;
            cmd_cnt_r <= 4'h0;
            tx_active_r <= 1'b0;
            tx_rise_r <= 1'b0;
            dout_r <= 1'b0;
        end
        else
        begin
            if (sclk_rise)
            begin
                cmd_sh_r <= cmd_byte;
                cmd_cnt_r <= cmd_done ? 4'h0 : cmd_cnt_r + 4'h1;
            end
            if (cmd_done)
            begin
                case (cmd_byte)
                    `ACR_CMD_STOP_CONT:
                        cmd_read_mode_r <= 1'b1;
                    `ACR_CMD_READ_DATA:
                        if (cmd_read_mode_r)
                        begin
                            // A new read retires the previous word, whole or cut short
                            read_pend_r <= 1'b1;
                            tx_active_r <= 1'b0;
                        end
                    `ACR_CMD_OFS_CAL:
                        if (!sinc_mode)
                        begin
                            cal_start_r <= 1'b1;
                            cal_start_gain_r <= 1'b0;
                        end
                    `ACR_CMD_GAIN_CAL:
                        if (!sinc_mode)
                        begin
                            cal_start_r <= 1'b1;
                            cal_start_gain_r <= 1'b1;
                        end
                    default:
                        cmd_read_mode_r <= cmd_read_mode_r;
                endcase
            end
            if (tx_load)
            begin
                // Strobe falls with the MSB already on the output
                read_pend_r <= 1'b0;
                tx_sh_r <= {result_r[30:0], 1'b0};
                dout_r <= result_r[31];
                data_ready_n_r <= 1'b0;
                tx_cnt_r <= 6'h01;
                tx_active_r <= 1'b1;
                tx_rise_r <= 1'b0;
            end
            else if (tx_active_r && sclk_rise)
                tx_rise_r <= 1'b1;
            // The command's own last fall can trail the strobe; only falls after a host rise shift
            else if (tx_active_r && tx_rise_r && sclk_fall)
            begin
                data_ready_n_r <= 1'b1;
                if (tx_cnt_r == `ACR_WORD_BITS)
                    dout_r <= 1'b0;
                else
                begin
                    dout_r <= tx_sh_r[31];
                    tx_sh_r <= {tx_sh_r[30:0], 1'b0};
                    tx_cnt_r <= tx_cnt_r + 6'h01;
                end
            end
        end
    end
end

// ****************************************
// Calibration engine
// ****************************************
reg [37:0] acc_r;
reg [4:0] avg_cnt_r;
reg [52:0] num_r;
reg [33:0] den_r;
reg [34:0] rem_r;
reg [23:0] quo_r;
reg quo_ovf_r;
reg [5:0] div_cnt_r;
wire [34:0] rem_sh = {rem_r[33:0], num_r[52]};
wire rem_ge = rem_sh >= {1'b0, den_r};
wire [37:0] acc_in = cal_gain_r ? {{4{diff[33]}}, diff} : {{6{conv_data[31]}}, conv_data};
wire [37:0] acc_sum = acc_r + acc_in;
wire [31:0] expected = `ACR_FS_EXPECTED;

// Sixteen samples averaged, then offset stored or gain divided bit-serially
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        cal_state_r <= CAL_IDLE;
        cal_gain_r <= 1'b0;
        cal_busy_r <= 1'b0;
        acc_r <= 38'h0000000000;
        avg_cnt_r <= 5'h00;
        num_r <= 53'h00000000000000;
        den_r <= 34'h000000000;
        rem_r <= 35'h000000000;
        quo_r <= 24'h000000;
        quo_ovf_r <= 1'b0;
        div_cnt_r <= 6'h00;
        offset_corr_word_r <= `ACR_OFS_RESET;
        gain_corr_word_r <= `ACR_GAIN_RESET;
    end
    else
    begin
        // Byte writes from the register port; calibration results land last
        if (reg_wr)
        begin
            case (reg_sel)
                `ACR_SEL_OFS_LOW: offset_corr_word_r[7:0] <= reg_wdata;
                `ACR_SEL_OFS_MID: offset_corr_word_r[15:8] <= reg_wdata;
                `ACR_SEL_OFS_HIGH: offset_corr_word_r[23:16] <= reg_wdata;
                `ACR_SEL_GAIN_LOW: gain_corr_word_r[7:0] <= reg_wdata;
                `ACR_SEL_GAIN_MID: gain_corr_word_r[15:8] <= reg_wdata;
                `ACR_SEL_GAIN_HIGH: gain_corr_word_r[23:16] <= reg_wdata;
                default: quo_ovf_r <= quo_ovf_r;
            endcase
        end
        case (cal_state_r)
            CAL_IDLE:
                if (cal_start_r)
                begin
                    cal_state_r <= CAL_ACC;
                    cal_gain_r <= cal_start_gain_r;
                    cal_busy_r <= 1'b1;
                    acc_r <= 38'h0000000000;
                    avg_cnt_r <= 5'h00;
                end
            CAL_ACC:
                if (sinc_mode)
                begin
                    cal_state_r <= CAL_IDLE;
                    cal_busy_r <= 1'b0;
                end
                else if (conv_valid)
                begin
                    acc_r <= acc_sum;
                    avg_cnt_r <= avg_cnt_r + 5'h01;
                    if (avg_cnt_r == `ACR_CAL_AVG - 5'h01)
                    begin
                        if (!cal_gain_r)
                        begin
                            // Truncated average, top 24 bits of the word
                            offset_corr_word_r <= acc_sum[35:12];
                            cal_state_r <= CAL_IDLE;
                            cal_busy_r <= 1'b0;
                        end
                        else if (acc_sum[37] || acc_sum[37:4] == 34'h000000000)
                        begin
                            // No usable positive reading, gain left untouched
                            cal_state_r <= CAL_IDLE;
                            cal_busy_r <= 1'b0;
                        end
                        else
                        begin
                            den_r <= acc_sum[37:4];
                            num_r <= {expected[30:0], 22'h000000};
                            rem_r <= 35'h000000000;
                            quo_r <= 24'h000000;
                            quo_ovf_r <= 1'b0;
                            div_cnt_r <= 6'h00;
                            cal_state_r <= CAL_DIV;
                        end
                    end
                end
            CAL_DIV:
            begin
                // Expected code times 400000h over measured average
                num_r <= {num_r[51:0], 1'b0};
                rem_r <= rem_ge ? rem_sh - {1'b0, den_r} : rem_sh;
                quo_r <= {quo_r[22:0], rem_ge};
                quo_ovf_r <= quo_ovf_r | quo_r[23];
                div_cnt_r <= div_cnt_r + 6'h01;
                if (div_cnt_r == `ACR_DIV_BITS - 6'h01)
                begin
                    gain_corr_word_r <= (quo_ovf_r | quo_r[23]) ? 24'hFFFFFF
                                        : {quo_r[22:0], rem_ge};
                    cal_state_r <= CAL_IDLE;
                    cal_busy_r <= 1'b0;
                end
            end
            default:
            begin
                cal_state_r <= CAL_IDLE;
                cal_busy_r <= 1'b0;
            end
        endcase
    end
end

endmodule

// file: dv/acr_core_monitor.sv
`timescale 1ns/100ps
// ****
// Port checker for the core
// ****
module acr_core_monitor
(
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Serial pins
    input wire cs_n,
    input wire sclk,
    input wire din,
    input wire dout_r,
    input wire dout_oe_n_r,
    input wire data_ready_n_r,
    // Conversion stream
    input wire [31:0] conv_data,
    input wire conv_valid,
    input wire sinc_mode,
    // Byte writes
    input wire reg_wr,
    input wire [2:0] reg_sel,
    input wire [7:0] reg_wdata,
    // Status
    input wire [23:0] offset_corr_word_r,
    input wire [23:0] gain_corr_word_r,
    input wire cmd_read_mode_r,
    input wire cal_busy_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Host clocked a readback bit; the command's own last rise comes before the strobe
    logic rise_seen_r;
    logic sclk_q_r;
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rise_seen_r <= 1'b0;
            sclk_q_r <= 1'b0;
        end
        else
        begin
            sclk_q_r <= sclk;
            rise_seen_r <= !data_ready_n_r && (rise_seen_r || (sclk && !sclk_q_r));
        end
    end
    // Strobe steps: the fall, then held low for eight cycles counting the fall cycle
    sequence s_fall;
        $fell(data_ready_n_r);
    endsequence
    sequence s_hold;
        !data_ready_n_r [*8];
    endsequence
    a_strobe_mode: assert property (s_fall |-> cmd_read_mode_r)
        else $error("strobe fell outside command-read mode");
    a_strobe_hold: assert property (s_fall |-> s_hold)
        else $error("strobe released before host clocked");
    a_strobe_drive: assert property (s_fall |-> !dout_oe_n_r)
        else $error("serial out not driven at strobe");
    a_strobe_release: assert property (rise_seen_r && $fell(sclk) |-> ##[1:8] data_ready_n_r)
        else $error("strobe not released on first falling edge");
    a_mode_cleared: assert property (cs_n [*7] |-> !cmd_read_mode_r)
        else $error("mode kept with chip select high");
    a_sinc_offset: assert property (sinc_mode && !reg_wr && !cal_busy_r |=> $stable(offset_corr_word_r))
        else $error("offset word changed in sinc mode");
    a_sinc_busy: assert property (sinc_mode && !cal_busy_r |=> !cal_busy_r)
        else $error("calibration started in sinc mode");
    a_offset_write: assert property (reg_wr && reg_sel == 3'h0 && !cal_busy_r
        |=> offset_corr_word_r[7:0] == $past(reg_wdata))
        else $error("offset low byte not written");
    a_gain_write: assert property (reg_wr && reg_sel == 3'h6 && !cal_busy_r
        |=> gain_corr_word_r[23:16] == $past(reg_wdata))
        else $error("gain high byte not written");
endmodule

// file: dv/acr_host.sv
`timescale 1ns/100ps
// ****
// Host serial master model
// ****
module acr_host
(
    // Pins driven by the host
    output logic cs_n,
    output logic sclk,
    output logic din,
    // Pins from the device
    input wire dout_r,
    input wire dout_oe_n_r,
    input wire data_ready_n_r
);
    localparam real HALF = 62.5;
    // Idle: deselected, clock low, data low
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // Chip select; raising it drops command-read mode
    task sel(input logic v);
        #HALF cs_n = v;
        #HALF;
    endtask
    // One command byte MSB first, data changed only while the clock is low
    task send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            din = b[i];
            #HALF sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
        din = 1'b0; // Readback clocks also reach the command receiver
    endtask
    // Waits for the strobe, then shifts n bits; undriven data reads as unknown
    task read_word(input int n, output logic [31:0] q);
        int t;
        q = 32'h0;
        t = 0;
        while (data_ready_n_r !== 1'b0 && t < 4000)
        begin
            #8 t++;
        end
        for (int i = 0; i < n; i++)
        begin
            #HALF sclk = 1'b1;
            q = {q[30:0], dout_oe_n_r ? 1'bx : dout_r};
            #HALF sclk = 1'b0;
        end
    endtask
endmodule

// file: dv/adc_calibration_and_readout_test.sv
`timescale 1ns/100ps
`include "acr_defs.vh"
module adc_calibration_and_readout_test;
    // ****
    // Signals
    // ****
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    wire cs_n, sclk, din, dout_r, dout_oe_n_r, data_ready_n_r;
    logic [31:0] conv_data = 32'h0;
    logic conv_valid = 1'b0;
    logic sinc_mode = 1'b0;
    logic reg_wr = 1'b0;
    logic [2:0] reg_sel = 3'h0;
    logic [7:0] reg_wdata = 8'h0;
    wire [23:0] offset_corr_word_r, gain_corr_word_r;
    wire cmd_read_mode_r, cal_busy_r;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [31:0] q;
    typedef struct packed {
        logic [23:0] ofs;
        logic [23:0] gain;
        logic sinc;
        logic [31:0] raw;
        logic [31:0] res;
    } acr_row_t;
    // Offset, gain, sinc path, raw word, expected word; two rows clip to full scale
    acr_row_t rows [11] = '{
        '{24'h000000, 24'h400000, 1'b0, 32'h00001000, 32'h00001000},
        '{24'h000000, 24'h400000, 1'b0, 32'hFFFFF000, 32'hFFFFF001},
        '{24'h000001, 24'h400000, 1'b0, 32'h00000000, 32'hFFFFFF01},
        '{24'hFFFFFF, 24'h400000, 1'b0, 32'h00000000, 32'h00000100},
        '{24'h000000, 24'h433333, 1'b0, 32'h00400000, 32'h00433332},
        '{24'h000000, 24'h3CCCCC, 1'b0, 32'h00400000, 32'h003CCCCC},
        '{24'h000000, 24'h800000, 1'b0, 32'h40000000, 32'h7FFFFFFF},
        '{24'h000000, 24'h800000, 1'b0, 32'h80000000, 32'h80000000},
        '{24'h000100, 24'h800000, 1'b0, 32'h00020000, 32'h00020000},
        '{24'h000100, 24'h800000, 1'b1, 32'h00020000, 32'h00010000},
        '{24'h000100, 24'h800000, 1'b1, 32'h80000002, 32'hC0000001}
    };
    // Free-running system clock
    always #4 sys_clk = ~sys_clk;
    acr_core u_acr_core (.*);
    acr_host u_acr_host (.*);
    // ****
    // Tasks
    // ****
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Pulses are one cycle wide with a gap, so no signal is set twice in a step
    task wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_sel <= s;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task conv(input logic [31:0] d);
        @(posedge sys_clk);
        conv_valid <= 1'b1;
        conv_data <= d;
        @(posedge sys_clk);
        conv_valid <= 1'b0;
    endtask
    task set_cal(input logic [23:0] o, input logic [23:0] g);
        for (int k = 0; k < 3; k++)
        begin
            wr(3'(k), o[8*k+:8]);
            wr(3'(k + 4), g[8*k+:8]);
        end
    endtask
    // Bounded wait for calibration, then a settled sample point
    task wait_cal;
        for (int t = 0; t < 300 && cal_busy_r !== 1'b0; t++)
            @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task read_chk(input logic [31:0] raw, input logic [31:0] exp);
        conv(raw);
        u_acr_host.send_byte(`ACR_CMD_READ_DATA);
        u_acr_host.read_word(32, q);
        chk_word(q, exp);
    endtask
    task end_sim;
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Hang guard, well past the expected run length
    initial
    begin
        #600000;
        n_mismatch++;
        end_sim;
    end
    // ****
    // Main sequence
    // ****
    initial
    begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        chk_word({8'h00, offset_corr_word_r}, 32'h00000000);
        chk_word({8'h00, gain_corr_word_r}, 32'h00400000);
        chk_bit(data_ready_n_r, 1'b1);
        chk_bit(cmd_read_mode_r, 1'b0);
        // Serial out stays released while the select pin is still high
        repeat (2) @(negedge sys_clk);
        chk_bit(dout_oe_n_r, 1'b1);
        repeat (8) @(posedge sys_clk);
        u_acr_host.sel(1'b0);
        conv(32'h00001000);
        u_acr_host.send_byte(`ACR_CMD_READ_DATA);
        repeat (100) @(posedge sys_clk);
        chk_bit(data_ready_n_r, 1'b1);
        u_acr_host.send_byte(`ACR_CMD_STOP_CONT);
        repeat (8) @(posedge sys_clk);
        chk_bit(cmd_read_mode_r, 1'b1);
        for (int i = 0; i < 11; i++)
        begin
            set_cal(rows[i].ofs, rows[i].gain);
            sinc_mode <= rows[i].sinc;
            read_chk(rows[i].raw, rows[i].res);
        end
        @(posedge sys_clk);
        sinc_mode <= 1'b0;
        // Unmapped selects leave both words alone
        set_cal(24'h000000, 24'h400000);
        wr(3'h3, 8'hAA);
        wr(3'h7, 8'hAA);
        @(negedge sys_clk);
        chk_word({offset_corr_word_r, 8'h00}, 32'h00000000);
        chk_word({8'h00, gain_corr_word_r}, 32'h00400000);
        // Short readback, then a full word must still come out whole
        conv(32'h12345600);
        u_acr_host.send_byte(`ACR_CMD_READ_DATA);
        u_acr_host.read_word(24, q);
        chk_word(q, 32'h00123456);
        read_chk(32'h00000200, 32'h00000200);
        // Deselect drops the mode; a read before the stop command is ignored
        u_acr_host.sel(1'b1);
        repeat (4) @(posedge sys_clk);
        chk_bit(cmd_read_mode_r, 1'b0);
        u_acr_host.sel(1'b0);
        conv(32'h00000300);
        u_acr_host.send_byte(`ACR_CMD_READ_DATA);
        repeat (100) @(posedge sys_clk);
        chk_bit(data_ready_n_r, 1'b1);
        u_acr_host.send_byte(`ACR_CMD_STOP_CONT);
        read_chk(32'h00000400, 32'h00000400);
        // Offset calibration with gain 2 set; the gain must not touch the average
        set_cal(24'h000000, 24'h800000);
        u_acr_host.send_byte(`ACR_CMD_OFS_CAL);
        @(negedge sys_clk);
        chk_bit(cal_busy_r, 1'b1);
        for (int k = 0; k < 15; k++)
            conv(32'h00012300 + k);
        // Last sample read back unscaled although the gain is two
        read_chk(32'h0001230F, 32'h0001230E);
        wait_cal;
        chk_word({8'h00, offset_corr_word_r}, 32'h00000123);
        // Gain calibration on a half-scale input
        set_cal(24'h000000, 24'h400000);
        u_acr_host.send_byte(`ACR_CMD_GAIN_CAL);
        for (int k = 0; k < 16; k++)
            conv(32'h40000000);
        wait_cal;
        chk_word({8'h00, gain_corr_word_r}, 32'h007FFFFF);
        // Calibration commands are refused on the sinc path
        @(posedge sys_clk);
        sinc_mode <= 1'b1;
        u_acr_host.send_byte(`ACR_CMD_OFS_CAL);
        for (int k = 0; k < 16; k++)
            conv(32'h00012300);
        wait_cal;
        chk_bit(cal_busy_r, 1'b0);
        chk_word({8'h00, offset_corr_word_r}, 32'h00000000);
        end_sim;
    end
endmodule
bind acr_core acr_core_monitor u_acr_core_monitor (.*);
